/* File: logic/lro_defines.svh */
// Register map, field positions, reset values and depths of the receive output stage
`ifndef LRO_DEFINES_SVH
`define LRO_DEFINES_SVH

// Register byte offsets on the bus
`define LRO_CTRL_OFS 4'h0
`define LRO_STATUS_OFS 4'h4
`define LRO_MASK_OFS 4'h8
`define LRO_STATE_OFS 4'hC

// Control field positions
`define LRO_CTRL_INVERT_BIT 0
`define LRO_CTRL_SINGLE_BIT 1
`define LRO_CTRL_DECODE_BIT 2
`define LRO_CTRL_HDB3_BIT 3
`define LRO_CTRL_WIDTH 4

// Event positions in status and mask
`define LRO_EVT_LCV0_BIT 0
`define LRO_EVT_LCV1_BIT 1
`define LRO_EVT_SUB0_BIT 2
`define LRO_EVT_SUB1_BIT 3
`define LRO_EVT_WIDTH 4

// Live state field positions
`define LRO_STATE_INVERT_BIT 0
`define LRO_STATE_HOST_BIT 1
`define LRO_STATE_PIN_BIT 2

// Reset values
`define LRO_CTRL_RST 4'h0
`define LRO_MASK_RST 4'h0
`define LRO_STATUS_RST 4'h0

// Decoder delay line and how far back a substitution reaches
`define LRO_DELAY_DEPTH 4
`define LRO_HDB3_BACK 3
`define LRO_B3ZS_BACK 2

// Pin synchroniser width
`define LRO_SYNC_WIDTH 8

`endif

/* File: logic/lro_pkg.sv */
// Types shared by the receive output stage modules
`default_nettype none
package lro_pkg;
	// Control register layout, bit 0 at the right
	typedef struct packed {
		logic hdb3;
		logic decodeEn;
		logic singleRail;
		logic clkInvert;
	} lro_ctrl_t;

	// Sticky event vector
	typedef logic [3:0] lro_evt_t;
endpackage
`default_nettype wire

/* File: logic/lro_chan_if.sv */
// Per-channel link between the stage top and one channel decoder
`default_nettype none
interface lro_chan_if;
	logic step;
	logic linePos;
	logic lineNeg;
	logic singleRail;
	logic decodeEn;
	logic hdb3;
	logic railPos;
	logic railNeg;
	logic violation;
	logic substitution;

	modport top(
		output step,
		output linePos,
		output lineNeg,
		output singleRail,
		output decodeEn,
		output hdb3,
		input railPos,
		input railNeg,
		input violation,
		input substitution
	);

	modport chan(
		input step,
		input linePos,
		input lineNeg,
		input singleRail,
		input decodeEn,
		input hdb3,
		output railPos,
		output railNeg,
		output violation,
		output substitution
	);
endinterface
`default_nettype wire

/* File: logic/lro_chan_decode.sv */
// One receive channel: rail output, violation flag and substitution removal
`include "lro_defines.svh"
`default_nettype none
module lro_chan_decode #(
	parameter int DEPTH = `LRO_DELAY_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	lro_chan_if.chan ch
);
	logic [DEPTH-1:0] dataDly_q, dataDly_d;
	logic [DEPTH-1:0] lcvDly_q, lcvDly_d;
	logic [1:0] rawHist_q, rawHist_d;
	logic lastPos_q, lastPos_d;
	logic seenPulse_q, seenPulse_d;
	logic railPos_q, railPos_d;
	logic railNeg_q, railNeg_d;
	logic viol_q, viol_d;
	logic subst_q, subst_d;
	logic pulse, bipolarViol, pattern, isSub;

	// Next state, advanced once per recovered clock period
	always_comb begin
		pulse = ch.linePos | ch.lineNeg;
		bipolarViol = pulse & seenPulse_q & (ch.linePos == lastPos_q);
		// Zeros ahead of the violation mark a substitution, not a line fault
		pattern = ch.hdb3 ? (rawHist_q == 2'h0) : ~rawHist_q[0];
		isSub = ch.singleRail & ch.decodeEn & bipolarViol & pattern;
		dataDly_d = dataDly_q;
		lcvDly_d = lcvDly_q;
		rawHist_d = rawHist_q;
		lastPos_d = lastPos_q;
		seenPulse_d = seenPulse_q;
		railPos_d = railPos_q;
		railNeg_d = railNeg_q;
		viol_d = 1'b0;
		subst_d = 1'b0;
		if (ch.step) begin
			rawHist_d = {rawHist_q[0], pulse};
			if (pulse) begin
				lastPos_d = ch.linePos;
				seenPulse_d = 1'b1;
			end
			dataDly_d = {dataDly_q[DEPTH-2:0], pulse & ~isSub};
			lcvDly_d = {lcvDly_q[DEPTH-2:0], bipolarViol & ~isSub};
			// Clear the leading B or zero of the pattern too
			if (isSub) begin
				if (ch.hdb3) begin
					dataDly_d[`LRO_HDB3_BACK] = 1'b0;
				end else begin
					dataDly_d[`LRO_B3ZS_BACK] = 1'b0;
				end
			end
			if (ch.singleRail) begin
				// Delay lets a late V erase the bits ahead of it
				railPos_d = dataDly_d[DEPTH-1];
				railNeg_d = lcvDly_d[DEPTH-1];
				viol_d = bipolarViol & ~isSub;
				subst_d = isSub;
			end else begin
				railPos_d = ch.linePos;
				railNeg_d = ch.lineNeg;
			end
		end
	end

	// Channel state registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dataDly_q <= '0;
			lcvDly_q <= '0;
			rawHist_q <= 2'h0;
			lastPos_q <= 1'b0;
			seenPulse_q <= 1'b0;
			railPos_q <= 1'b0;
			railNeg_q <= 1'b0;
			viol_q <= 1'b0;
			subst_q <= 1'b0;
		end else begin
			dataDly_q <= dataDly_d;
			lcvDly_q <= lcvDly_d;
			rawHist_q <= rawHist_d;
			lastPos_q <= lastPos_d;
			seenPulse_q <= seenPulse_d;
			railPos_q <= railPos_d;
			railNeg_q <= railNeg_d;
			viol_q <= viol_d;
			subst_q <= subst_d;
		end
	end

	// Results back to the top
	assign ch.railPos = railPos_q;
	assign ch.railNeg = railNeg_q;
	assign ch.violation = viol_q;
	assign ch.substitution = subst_q;
endmodule
`default_nettype wire

/* File: logic/lro_line_receive_output_stage.sv */
// Two-channel receive output stage with Wishbone registers and interrupt
//
// Summary of operation
// - By default rail outputs change on the falling edge of the recovered clock output so the far end samples them on its rising edge.
// - With the polarity bit set or, in hardware mode, the polarity pin high, the rails are timed to be sampled on the falling edge of the recovered clock output.
// - In hardware mode a high polarity pin inverts both channels' clock outputs together and data launches on the internal falling edge.
// - In host mode the shared polarity pin is no clock control but the serial port's chip select.
// - With the decoder on in single-rail mode, substitution patterns are found and put out as zeros.
// - In dual-rail mode each negative line pulse appears on the negative rail output.
// - In single-rail mode the negative rail output flags each line code violation.
`include "lro_defines.svh"
`default_nettype none
module lro_line_receive_output_stage #(
	parameter int DEPTH = `LRO_DELAY_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	// Wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq,
	// Recovered clocks and line pulses from clock recovery
	input wire logic recoveredClockInCh0,
	input wire logic recoveredClockInCh1,
	input wire logic lineInPositiveCh0,
	input wire logic lineInNegativeCh0,
	input wire logic lineInPositiveCh1,
	input wire logic lineInNegativeCh1,
	// Mode and shared polarity pin
	input wire logic hostModePin,
	input wire logic polarityOrSelectPin,
	output logic serialSelectN,
	// Outputs to the framer
	output logic recoveredClockOutCh0,
	output logic recoveredClockOutCh1,
	output logic positiveRailOutCh0,
	output logic positiveRailOutCh1,
	output logic negativeRailOrViolationCh0,
	output logic negativeRailOrViolationCh1
);
	// Word-aligned register decode shared by reads and writes
	function automatic logic regHit(input logic [3:0] adr, input logic [3:0] ofs);
		regHit = (adr[3:2] == ofs[3:2]);
	endfunction

	lro_pkg::lro_ctrl_t ctrl_q, ctrl_d;
	lro_pkg::lro_evt_t status_q, status_d;
	lro_pkg::lro_evt_t mask_q, mask_d;
	lro_pkg::lro_evt_t events;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic irq_q, irq_d;
	logic [`LRO_SYNC_WIDTH-1:0] syncA_q, syncA_d;
	logic [`LRO_SYNC_WIDTH-1:0] syncB_q, syncB_d;
	logic [1:0] clkPrev_q, clkPrev_d;
	logic clkOut0_q, clkOut0_d;
	logic clkOut1_q, clkOut1_d;
	logic selN_q, selN_d;
	logic req, hostSync, pinSync, invertEff;
	logic fall0, fall1;

	lro_chan_if chIf0();
	lro_chan_if chIf1();

	// Pin sampling: raw vector into first stage, first into second only
	always_comb begin
		syncA_d = {hostModePin, polarityOrSelectPin, lineInNegativeCh1, lineInPositiveCh1,
			recoveredClockInCh1, lineInNegativeCh0, lineInPositiveCh0, recoveredClockInCh0};
		syncB_d = syncA_q;
		clkPrev_d = {syncB_q[3], syncB_q[0]};
	end

	// Synchroniser and edge history registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
			clkPrev_q <= 2'h0;
		end else begin
			syncA_q <= syncA_d;
			syncB_q <= syncB_d;
			clkPrev_q <= clkPrev_d;
		end
	end

	// Decode the synchronised pins
	assign hostSync = syncB_q[7];
	assign pinSync = syncB_q[6];
	// Host mode hands the pin to the serial port, so it no longer inverts
	assign invertEff = ctrl_q.clkInvert | (~hostSync & pinSync);
	// Internal falling edge of each recovered clock, one step per period
	assign fall0 = clkPrev_q[0] & ~syncB_q[0];
	assign fall1 = clkPrev_q[1] & ~syncB_q[3];

	// Channel 0 feed; rails always launch on the internal falling edge
	assign chIf0.step = fall0;
	assign chIf0.linePos = syncB_q[1];
	assign chIf0.lineNeg = syncB_q[2];
	assign chIf0.singleRail = ctrl_q.singleRail;
	assign chIf0.decodeEn = ctrl_q.decodeEn;
	assign chIf0.hdb3 = ctrl_q.hdb3;

	// Channel 1 feed, stepped by its own recovered clock
	assign chIf1.step = fall1;
	assign chIf1.linePos = syncB_q[4];
	assign chIf1.lineNeg = syncB_q[5];
	assign chIf1.singleRail = ctrl_q.singleRail;
	assign chIf1.decodeEn = ctrl_q.decodeEn;
	assign chIf1.hdb3 = ctrl_q.hdb3;

	lro_chan_decode #(
		.DEPTH(DEPTH)
	) uChan0 (
		.clk(clk),
		.reset_n(reset_n),
		.ch(chIf0)
	);

	lro_chan_decode #(
		.DEPTH(DEPTH)
	) uChan1 (
		.clk(clk),
		.reset_n(reset_n),
		.ch(chIf1)
	);

	// Clock outputs follow the sampled clock, flipped together when inverted
	always_comb begin
		clkOut0_d = syncB_q[0] ^ invertEff;
		clkOut1_d = syncB_q[3] ^ invertEff;
		// Chip select is active low; idle high in hardware mode
		selN_d = hostSync ? pinSync : 1'b1;
	end

	// Output clock and select registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clkOut0_q <= 1'b0;
			clkOut1_q <= 1'b0;
			selN_q <= 1'b1;
		end else begin
			clkOut0_q <= clkOut0_d;
			clkOut1_q <= clkOut1_d;
			selN_q <= selN_d;
		end
	end

	// Events from the channels, one-cycle pulses
	always_comb begin
		events = '0;
		events[`LRO_EVT_LCV0_BIT] = chIf0.violation;
		events[`LRO_EVT_LCV1_BIT] = chIf1.violation;
		events[`LRO_EVT_SUB0_BIT] = chIf0.substitution;
		events[`LRO_EVT_SUB1_BIT] = chIf1.substitution;
	end

	// Bus slave: one wait state, ack for exactly one cycle per request
	assign req = cyc_i & stb_i & ~ack_q;

	// Register next values; a new event wins over a read that clears
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		status_d = status_q;
		dat_d = dat_q;
		ack_d = req;
		if (req && we_i && sel_i[0]) begin
			if (regHit(adr_i, `LRO_CTRL_OFS)) begin
				ctrl_d = lro_pkg::lro_ctrl_t'(dat_i[`LRO_CTRL_WIDTH-1:0]);
			end
			if (regHit(adr_i, `LRO_MASK_OFS)) begin
				mask_d = dat_i[`LRO_EVT_WIDTH-1:0];
			end
		end
		if (req && !we_i) begin
			dat_d = 32'h0000_0000;
			if (regHit(adr_i, `LRO_CTRL_OFS)) begin
				dat_d[`LRO_CTRL_WIDTH-1:0] = ctrl_q;
			end
			if (regHit(adr_i, `LRO_STATUS_OFS)) begin
				dat_d[`LRO_EVT_WIDTH-1:0] = status_q;
				status_d = '0;
			end
			if (regHit(adr_i, `LRO_MASK_OFS)) begin
				dat_d[`LRO_EVT_WIDTH-1:0] = mask_q;
			end
			if (regHit(adr_i, `LRO_STATE_OFS)) begin
				dat_d[`LRO_STATE_INVERT_BIT] = invertEff;
				dat_d[`LRO_STATE_HOST_BIT] = hostSync;
				dat_d[`LRO_STATE_PIN_BIT] = pinSync;
			end
		end
		status_d = status_d | events;
		irq_d = |(status_d & mask_d);
	end

	// Register file and bus answer registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= lro_pkg::lro_ctrl_t'(`LRO_CTRL_RST);
			mask_q <= `LRO_MASK_RST;
			status_q <= `LRO_STATUS_RST;
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			status_q <= status_d;
			dat_q <= dat_d;
			ack_q <= ack_d;
			irq_q <= irq_d;
		end
	end

	// Outputs, each straight from a flip-flop
	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign irq = irq_q;
	assign serialSelectN = selN_q;
	assign recoveredClockOutCh0 = clkOut0_q;
	assign recoveredClockOutCh1 = clkOut1_q;
	assign positiveRailOutCh0 = chIf0.railPos;
	assign positiveRailOutCh1 = chIf1.railPos;
	assign negativeRailOrViolationCh0 = chIf0.railNeg;
	assign negativeRailOrViolationCh1 = chIf1.railNeg;
endmodule
`default_nettype wire

/* File: dv/lro_stage_chk.sv */
// Port-level timing and pin-role checks for the receive output stage
`default_nettype none
module lro_stage_chk #(
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hostModePin,
	input wire logic polarityOrSelectPin,
	input wire logic serialSelectN,
	input wire logic recoveredClockInCh0,
	input wire logic recoveredClockInCh1,
	input wire logic recoveredClockOutCh0,
	input wire logic recoveredClockOutCh1,
	input wire logic positiveRailOutCh0,
	input wire logic positiveRailOutCh1,
	input wire logic negativeRailOrViolationCh0
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Inversion pin held long enough to clear the synchroniser
	sequence hwInv;
		(!hostModePin && polarityOrSelectPin)[*6];
	endsequence
	a_pos_edge: assert property (
		!$stable(positiveRailOutCh0) |-> !$stable(recoveredClockOutCh0))
		else $error("ch0 rail moved off a clock edge");
	a_neg_edge: assert property (
		!$stable(negativeRailOrViolationCh0) |-> !$stable(recoveredClockOutCh0))
		else $error("ch0 negative rail moved off a clock edge");
	a_own_clock: assert property (
		!$stable(positiveRailOutCh1) |-> !$stable(recoveredClockOutCh1))
		else $error("ch1 rail moved off its own clock edge");
	a_inv_launch: assert property (
		hwInv ##0 $changed(positiveRailOutCh0) |-> $rose(recoveredClockOutCh0))
		else $error("inverted rail not launched at clock rise");
	a_inv_clk0: assert property (
		hwInv ##0 $fell(recoveredClockInCh0) |-> ##[1:5] $rose(recoveredClockOutCh0))
		else $error("ch0 clock not inverted");
	a_inv_clk1: assert property (
		hwInv ##0 $fell(recoveredClockInCh1) |-> ##[1:5] $rose(recoveredClockOutCh1))
		else $error("ch1 clock not inverted");
	a_select_host: assert property (
		(hostModePin && $stable(polarityOrSelectPin))[*6] |-> serialSelectN == polarityOrSelectPin)
		else $error("select does not follow the shared pin");
	a_select_idle: assert property (
		(!hostModePin)[*6] |-> serialSelectN)
		else $error("select active in hardware mode");
	c_inverted: cover property (hwInv ##0 $rose(recoveredClockOutCh0));
	c_selected: cover property (hostModePin && !serialSelectN);
	c_flag: cover property ($rose(negativeRailOrViolationCh0));
endmodule
bind lro_line_receive_output_stage lro_stage_chk #(.DEPTH(DEPTH)) i_chk (.clk, .reset_n,
	.hostModePin, .polarityOrSelectPin, .serialSelectN, .recoveredClockInCh0,
	.recoveredClockInCh1, .recoveredClockOutCh0, .recoveredClockOutCh1,
	.positiveRailOutCh0, .positiveRailOutCh1, .negativeRailOrViolationCh0);
`default_nettype wire

/* File: dv/lro_framer_model.sv */
// Framer-side sink counting marks sampled on each recovered clock output
`default_nettype none
module lro_framer_model (
	input wire logic clk0,
	input wire logic clk1,
	input wire logic pos0,
	input wire logic neg0,
	input wire logic pos1,
	input wire logic neg1,
	input wire logic onFall,
	output logic [7:0] posCnt0,
	output logic [7:0] negCnt0,
	output logic [7:0] posCnt1,
	output logic [7:0] negCnt1
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clean start, the bench works with differences only
	initial {posCnt0, negCnt0, posCnt1, negCnt1} = 32'h0;
	// Rising edge by default, falling edge when inverted
	always @(clk0) if (clk0 ^ onFall) begin
		posCnt0 <= posCnt0 + 8'(pos0);
		negCnt0 <= negCnt0 + 8'(neg0);
	end
	// Channel 1 on its own clock
	always @(clk1) if (clk1 ^ onFall) begin
		posCnt1 <= posCnt1 + 8'(pos1);
		negCnt1 <= negCnt1 + 8'(neg1);
	end
endmodule
`default_nettype wire

/* File: dv/lro_line_receive_output_stage_test.sv */
// Self-checking bench for the receive output stage
`include "lro_defines.svh"
`default_nettype none
module lro_line_receive_output_stage_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic ack_o, irq, serialSelectN, onFall = 1'b0;
	logic recoveredClockInCh0 = 1'b0, recoveredClockInCh1 = 1'b0;
	logic lineInPositiveCh0 = 1'b0, lineInNegativeCh0 = 1'b0;
	logic lineInPositiveCh1 = 1'b0, lineInNegativeCh1 = 1'b0;
	logic hostModePin = 1'b0, polarityOrSelectPin = 1'b0;
	logic recoveredClockOutCh0, recoveredClockOutCh1, positiveRailOutCh0, positiveRailOutCh1;
	logic negativeRailOrViolationCh0, negativeRailOrViolationCh1;
	logic [7:0] posCnt0, negCnt0, posCnt1, negCnt1;
	logic [2:0] phase = 3'h0;
	logic [1:0] sym = 2'h0;
	int fail_count = 0;
	int check_count = 0;
	lro_line_receive_output_stage i_dut (.clk, .reset_n, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .irq, .recoveredClockInCh0, .recoveredClockInCh1,
		.lineInPositiveCh0, .lineInNegativeCh0, .lineInPositiveCh1, .lineInNegativeCh1,
		.hostModePin, .polarityOrSelectPin, .serialSelectN, .recoveredClockOutCh0,
		.recoveredClockOutCh1, .positiveRailOutCh0, .positiveRailOutCh1,
		.negativeRailOrViolationCh0, .negativeRailOrViolationCh1);
	lro_framer_model i_framer (.clk0(recoveredClockOutCh0), .clk1(recoveredClockOutCh1),
		.pos0(positiveRailOutCh0), .neg0(negativeRailOrViolationCh0),
		.pos1(positiveRailOutCh1), .neg1(negativeRailOrViolationCh1), .onFall,
		.posCnt0, .negCnt0, .posCnt1, .negCnt1);
	initial forever #10 clk = ~clk;
	// 160 ns link clocks, ch1 two cycles earlier; symbols land well before each fall
	always @(posedge clk) begin
		phase <= phase + 3'h1;
		recoveredClockInCh0 <= phase[2];
		recoveredClockInCh1 <= (phase + 3'h2) >= 3'h4;
		if (phase == 3'h5) {lineInPositiveCh0, lineInNegativeCh0} <= {sym[0], sym[1]};
		if (phase == 3'h3) {lineInPositiveCh1, lineInNegativeCh1} <= {sym[0], sym[1]};
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Single classic cycle; only the watchdog ends a silent slave
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, we, a, 4'hF, d};
		do @(posedge clk); while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	// Symbols LSB first: 1 positive mark, 2 negative; zero tail flushes the decoder
	task automatic traffic(input logic [31:0] sq, input int ep, input int en);
		logic [7:0] b0, b1, b2, b3;
		int i;
		{b0, b1, b2, b3} = {posCnt0, negCnt0, posCnt1, negCnt1};
		for (i = 0; i < 24; i++) begin
			do @(posedge clk); while (phase != 3'h6);
			sym <= i < 16 ? sq[2 * i +: 2] : 2'h0;
		end
		check(32'(posCnt0 - b0), ep);
		check(32'(negCnt0 - b1), en);
		check(32'(posCnt1 - b2), ep);
		check(32'(negCnt1 - b3), en);
	endtask
	task automatic t_regs();
		logic [31:0] q;
		wb(1'b0, `LRO_MASK_OFS, 32'h0, q);
		check(q, 32'h0);
		wr(`LRO_CTRL_OFS, 32'hF);
		wb(1'b0, `LRO_CTRL_OFS, 32'h0, q);
		check(q, 32'hF);
		wr(`LRO_CTRL_OFS, 32'h0);
	endtask
	task automatic t_dual();
		logic [31:0] q;
		traffic(32'h9849, 3, 3);
		{polarityOrSelectPin, onFall} <= 2'h3;
		traffic(32'h9849, 3, 3);
		wb(1'b0, `LRO_STATE_OFS, 32'h0, q);
		check(q, 32'h5);
		{polarityOrSelectPin, onFall} <= 2'h0;
	endtask
	task automatic t_host();
		logic [31:0] q;
		{hostModePin, polarityOrSelectPin} <= 2'h3;
		// Let the pins clear the two-stage synchroniser first
		repeat (4) @(posedge clk);
		wb(1'b0, `LRO_STATE_OFS, 32'h0, q);
		check(q, 32'h6);
		polarityOrSelectPin <= 1'b0;
		wr(`LRO_CTRL_OFS, 32'h1);
		repeat (4) @(posedge clk);
		check({31'h0, serialSelectN}, 32'h0);
		onFall <= 1'b1;
		traffic(32'h9849, 3, 3);
		wb(1'b0, `LRO_STATE_OFS, 32'h0, q);
		check(q, 32'h3);
		wr(`LRO_CTRL_OFS, 32'h0);
		{hostModePin, onFall} <= 2'h0;
	endtask
	// Raise, clear by reading, then mask the interrupt
	task automatic t_single();
		logic [31:0] q;
		wr(`LRO_CTRL_OFS, 32'h2);
		traffic(32'h9849, 6, 0);
		wb(1'b0, `LRO_STATUS_OFS, 32'h0, q);
		wr(`LRO_MASK_OFS, 32'h3);
		traffic(32'h25, 3, 1);
		check({31'h0, irq}, 32'h1);
		wb(1'b0, `LRO_STATUS_OFS, 32'h0, q);
		check(q, 32'h3);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr(`LRO_MASK_OFS, 32'h0);
		traffic(32'h25, 3, 1);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_subst();
		logic [31:0] q;
		logic [31:0] sq [4] = '{32'h919, 32'h241, 32'h2419, 32'h901};
		int mk [4] = '{3, 2, 3, 2};
		int i;
		for (i = 0; i < 4; i++) begin
			wr(`LRO_CTRL_OFS, i < 2 ? 32'h6 : 32'hE);
			wb(1'b0, `LRO_STATUS_OFS, 32'h0, q);
			traffic(sq[i], mk[i], 0);
			wb(1'b0, `LRO_STATUS_OFS, 32'h0, q);
			check(q & 32'hC, 32'hC);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_dual();
		t_host();
		t_single();
		t_subst();
		report_and_stop();
	end
	// Watchdog well past the expected run length
	initial begin
		repeat (10000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
